// ### design/lvs_pkg.sv
/*
  Constants for the low-voltage supervisor: register addresses, field
  positions, reset values and filter sizing.
  Assumes an 8-bit special-function-register port driven by the CPU.
*/
package lvs_pkg;
  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] LVS_ADDR_CONTROL = 8'hBA;  // Control register 0
  localparam logic [7:0] LVS_ADDR_FLAGS   = 8'hBB;  // Flags and bypass
  localparam logic [7:0] LVS_ADDR_HIGH    = 8'hBC;  // High filter count
  localparam logic [7:0] LVS_ADDR_LOW     = 8'hBD;  // Low filter count

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int LVS_CTL_OE      = 6;  // Output enable
  localparam int LVS_CTL_CORE_RE = 5;  // Core reset enable
  localparam int LVS_CTL_MAIN_RE = 4;  // Main reset enable
  localparam int LVS_CTL_THR_HI  = 3;  // Threshold select msb
  localparam int LVS_CTL_THR_LO  = 2;  // Threshold select lsb
  localparam int LVS_CTL_CORE_DE = 1;  // Core detect enable
  localparam int LVS_CTL_MAIN_DE = 0;  // Main detect enable
  localparam logic [7:0] LVS_CTL_RESET = 8'h73;

  // ----------------------------------------------------------------------
  // Flags and bypass register fields
  // ----------------------------------------------------------------------
  localparam int LVS_FLG_OC_PND   = 6;  // Overcurrent pending
  localparam int LVS_FLG_CORE_PND = 5;  // Core low pending
  localparam int LVS_FLG_MAIN_PND = 4;  // Main low pending
  localparam int LVS_FLG_SYNC_BYP = 3;  // Main synchroniser bypass
  localparam int LVS_FLG_OC_BYP   = 2;  // Overcurrent filter bypass
  localparam int LVS_FLG_CORE_BYP = 1;  // Core filter bypass
  localparam int LVS_FLG_MAIN_BYP = 0;  // Main filter bypass
  localparam logic [3:0] LVS_BYP_RESET = 4'hF;

  // ----------------------------------------------------------------------
  // Filter counts
  // ----------------------------------------------------------------------
  localparam int         LVS_CNT_W      = 7;
  localparam logic [6:0] LVS_CNT_RESET  = 7'h02;
  localparam int         LVS_CHANNELS   = 3;  // Main, core, overcurrent
  localparam int         LVS_CH_MAIN    = 0;
  localparam int         LVS_CH_CORE    = 1;
  localparam int         LVS_CH_OC      = 2;
endpackage

// ### design/lvs_filt_if.sv
/*
  Carrier between the supervisor top and its deglitch filter bank.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface lvs_filt_if
  import lvs_pkg::*;
();
  logic [LVS_CHANNELS-1:0] raw;       // Raw (possibly synchronised) inputs
  logic [LVS_CHANNELS-1:0] bypass;    // Per-channel filter bypass
  logic [LVS_CNT_W-1:0]    high_cnt;  // High-level qualify count
  logic [LVS_CNT_W-1:0]    low_cnt;   // Low-level qualify count
  logic [LVS_CHANNELS-1:0] clean;     // Filtered anomaly levels

  modport top  (output raw, output bypass, output high_cnt, output low_cnt,
                input clean);
  modport bank (input raw, input bypass, input high_cnt, input low_cnt,
                output clean);
endinterface

// ### design/lvs_deglitch.sv
/*
  Deglitch filter bank, one counter per anomaly channel.
  Assumes filter_tick is a one-cycle pulse per filter-clock period.
*/
`timescale 1ns/1ps
module lvs_deglitch
  import lvs_pkg::*;
(
  input  wire logic  mclk,         // System clock
  input  wire logic  rst,          // Synchronous reset
  input  wire logic  filter_tick,  // Filter clock enable pulse
  lvs_filt_if.bank   fif           // Filter carrier
);

  // ----------------------------------------------------------------------
  // Per-channel qualify counters
  // ----------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < LVS_CHANNELS; ch++) begin : g_ch
      logic [LVS_CNT_W-1:0] run;  // Filter ticks input has disagreed with state
      logic                 lvl;  // Filtered level, one driver per channel
      // Count filter ticks while the input differs from the held level
      always_ff @(posedge mclk) begin
        if (rst) begin
          run <= '0;
          lvl <= 1'b0;
        end else if (fif.raw[ch] == lvl) begin
          run <= '0;  // Glitch ended, restart
        end else if (filter_tick) begin
          // A zero count still needs one tick, never a free pass
          if ((run + 7'h01) >= (lvl ? fif.low_cnt : fif.high_cnt)) begin
            lvl <= fif.raw[ch];
            run <= '0;
          end else begin
            run <= run + 7'h01;
          end
        end
      end
      // Bypass passes the input straight through
      assign fif.clean[ch] = fif.bypass[ch] ? fif.raw[ch] : lvl;
    end
  endgenerate
endmodule

// ### design/lvs_filter_tick.sv
/*
  Filter clock generator: selects one of four tick rates derived from mclk.
  Assumes the selector is static while filtering matters.
*/
`timescale 1ns/1ps
module lvs_filter_tick #(
  parameter int DIV_W = 12  // Width of free-running divider
) (
  input  wire logic       mclk,        // System clock
  input  wire logic       rst,         // Synchronous reset
  input  wire logic [1:0] select,      // Filter clock select
  output logic            tick         // One-cycle filter tick
);
  logic [DIV_W-1:0] div;  // Free-running divider
  logic [DIV_W-1:0] nxt;  // Divider plus one

  assign nxt = div + {{(DIV_W-1){1'b0}}, 1'b1};

  // Divider and tick select; a tick marks a wrap of the chosen stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      div  <= '0;
      tick <= 1'b0;
    end else begin
      div <= nxt;
      unique case (select)
        2'h0: tick <= 1'b1;                        // Every cycle
        2'h1: tick <= (nxt[3:0] == 4'h0);          // Divide by 16
        2'h2: tick <= (nxt[7:0] == 8'h00);         // Divide by 256
        2'h3: tick <= (nxt == '0);                 // Full divider
      endcase
    end
  end
endmodule

// ### design/lvs_supervisor.sv
/*
  Low-voltage supervisor: register file, input conditioning, pending flags,
  interrupt and system reset request.
  Assumes a single-cycle SFR write/read port from the CPU and raw analog
  flags held synchronous or made so by the synchroniser.
*/
// Function
// - Output enable gates interrupt and reset
// - Core low reset when core reset enabled
// - Main low reset when main reset enabled
// - Two-bit main threshold select, resets zero
// - Core detect enable, resets to one
// - Main detect enable, resets to one
// - Sticky overcurrent flag, write one clears
// - Sticky core low flag, write one clears
// - Sticky main low flag, write one clears
// - Main input synchroniser bypass, resets one
// - Overcurrent filter bypass, resets one
// - Core low filter bypass, resets one
// - Main low filter bypass, resets one
// - Seven-bit high filter count, resets two
// - Seven-bit low filter count, resets two
// - Filters count selected filter clock
// - Anomalies raise CPU interrupt
`timescale 1ns/1ps
module lvs_supervisor
  import lvs_pkg::*;
(
  input  wire logic       mclk,                         // System clock
  input  wire logic       rst,                          // Sync reset
  input  wire logic [7:0] sfr_addr,                     // SFR address
  input  wire logic       sfr_wr,                       // Write strobe
  input  wire logic       sfr_rd,                       // Read strobe
  input  wire logic [7:0] sfr_wdata,                    // Write data
  output logic      [7:0] sfr_rdata,                    // Read data
  input  wire logic [1:0] clock_config_five,            // Filter clock sel
  input  wire logic       main_low_raw,                 // Main supply low
  input  wire logic       core_low_raw,                 // Core supply low
  input  wire logic       overcurrent_raw,              // Core overcurrent
  output logic      [1:0] main_supply_threshold_select, // To detector
  output logic            core_supply_detect_enable,    // To detector
  output logic            main_supply_detect_enable,    // To detector
  output logic            supervisor_irq,               // CPU interrupt
  output logic            supervisor_reset              // System reset req
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]           supervisor_control;       // Control register 0
  logic                 core_overcurrent_pending; // Sticky flags
  logic                 core_low_pending;
  logic                 main_low_pending;
  logic                 main_low_sync_bypass;     // Bypass bits
  logic                 overcurrent_filter_bypass;
  logic                 core_low_filter_bypass;
  logic                 main_low_filter_bypass;
  logic [LVS_CNT_W-1:0] filter_high_count_value;  // Control register 2
  logic [LVS_CNT_W-1:0] filter_low_count_value;   // Control register 3

  logic supervisor_output_enable;  // Decoded control bits
  logic core_supply_reset_enable;
  logic main_supply_reset_enable;

  assign supervisor_output_enable = supervisor_control[LVS_CTL_OE];
  assign core_supply_reset_enable = supervisor_control[LVS_CTL_CORE_RE];
  assign main_supply_reset_enable = supervisor_control[LVS_CTL_MAIN_RE];

  // Write decodes
  logic wr_ctl;
  logic wr_flg;
  logic wr_hi;
  logic wr_lo;
  assign wr_ctl = sfr_wr && (sfr_addr == LVS_ADDR_CONTROL);
  assign wr_flg = sfr_wr && (sfr_addr == LVS_ADDR_FLAGS);
  assign wr_hi  = sfr_wr && (sfr_addr == LVS_ADDR_HIGH);
  assign wr_lo  = sfr_wr && (sfr_addr == LVS_ADDR_LOW);

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // Bit 7 is reserved and kept zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      supervisor_control <= LVS_CTL_RESET;
    end else if (wr_ctl) begin
      supervisor_control <= {1'b0, sfr_wdata[6:0]};
    end
  end

  // Detector controls are registered so outputs come from flip-flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      main_supply_threshold_select <= LVS_CTL_RESET[LVS_CTL_THR_HI:LVS_CTL_THR_LO];
      core_supply_detect_enable    <= LVS_CTL_RESET[LVS_CTL_CORE_DE];
      main_supply_detect_enable    <= LVS_CTL_RESET[LVS_CTL_MAIN_DE];
    end else begin
      main_supply_threshold_select <=
        supervisor_control[LVS_CTL_THR_HI:LVS_CTL_THR_LO];
      core_supply_detect_enable    <= supervisor_control[LVS_CTL_CORE_DE];
      main_supply_detect_enable    <= supervisor_control[LVS_CTL_MAIN_DE];
    end
  end

  // ----------------------------------------------------------------------
  // Bypass bits and filter counts
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      {main_low_sync_bypass, overcurrent_filter_bypass,
       core_low_filter_bypass, main_low_filter_bypass} <= LVS_BYP_RESET;
    end else if (wr_flg) begin
      main_low_sync_bypass      <= sfr_wdata[LVS_FLG_SYNC_BYP];
      overcurrent_filter_bypass <= sfr_wdata[LVS_FLG_OC_BYP];
      core_low_filter_bypass    <= sfr_wdata[LVS_FLG_CORE_BYP];
      main_low_filter_bypass    <= sfr_wdata[LVS_FLG_MAIN_BYP];
    end
  end

  // Counts: bit 7 reserved
  always_ff @(posedge mclk) begin
    if (rst) begin
      filter_high_count_value <= LVS_CNT_RESET;
      filter_low_count_value  <= LVS_CNT_RESET;
    end else begin
      if (wr_hi) begin
        filter_high_count_value <= sfr_wdata[6:0];
      end
      if (wr_lo) begin
        filter_low_count_value <= sfr_wdata[6:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Main input synchroniser
  // ----------------------------------------------------------------------
  logic main_sync_a;  // First stage, read only by second
  logic main_sync_b;  // Second stage
  logic main_cond;    // Selected main low level

  // Two-stage synchroniser against metastability
  always_ff @(posedge mclk) begin
    if (rst) begin
      main_sync_a <= 1'b0;
      main_sync_b <= 1'b0;
    end else begin
      main_sync_a <= main_low_raw;
      main_sync_b <= main_sync_a;
    end
  end

  // Bypass trades metastability safety for two cycles of latency
  assign main_cond = main_low_sync_bypass ? main_low_raw : main_sync_b;

  // ----------------------------------------------------------------------
  // Filter clock and deglitch bank
  // ----------------------------------------------------------------------
  logic       filter_tick;  // One pulse per filter clock period
  lvs_filt_if fif ();

  lvs_filter_tick u_tick (
    .mclk   (mclk),
    .rst    (rst),
    .select (clock_config_five),
    .tick   (filter_tick)
  );

  // Disabled detectors are forced quiet before filtering
  assign fif.raw[LVS_CH_MAIN]    = main_cond & main_supply_detect_enable;
  assign fif.raw[LVS_CH_CORE]    = core_low_raw & core_supply_detect_enable;
  assign fif.raw[LVS_CH_OC]      = overcurrent_raw;
  assign fif.bypass[LVS_CH_MAIN] = main_low_filter_bypass;
  assign fif.bypass[LVS_CH_CORE] = core_low_filter_bypass;
  assign fif.bypass[LVS_CH_OC]   = overcurrent_filter_bypass;
  assign fif.high_cnt            = filter_high_count_value;
  assign fif.low_cnt             = filter_low_count_value;

  lvs_deglitch u_deglitch (
    .mclk        (mclk),
    .rst         (rst),
    .filter_tick (filter_tick),
    .fif         (fif)
  );

  // ----------------------------------------------------------------------
  // Sticky pending flags
  // ----------------------------------------------------------------------
  logic main_seen;  // Filtered main low level
  logic core_seen;  // Filtered core low level
  logic oc_seen;    // Filtered overcurrent level
  assign main_seen = fif.clean[LVS_CH_MAIN];
  assign core_seen = fif.clean[LVS_CH_CORE];
  assign oc_seen   = fif.clean[LVS_CH_OC];

  // Set wins over a same-cycle write-one clear so no event is lost
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_overcurrent_pending <= 1'b0;
      core_low_pending         <= 1'b0;
      main_low_pending         <= 1'b0;
    end else begin
      if (oc_seen) begin
        core_overcurrent_pending <= 1'b1;
      end else if (wr_flg && sfr_wdata[LVS_FLG_OC_PND]) begin
        core_overcurrent_pending <= 1'b0;
      end
      if (core_seen) begin
        core_low_pending <= 1'b1;
      end else if (wr_flg && sfr_wdata[LVS_FLG_CORE_PND]) begin
        core_low_pending <= 1'b0;
      end
      if (main_seen) begin
        main_low_pending <= 1'b1;
      end else if (wr_flg && sfr_wdata[LVS_FLG_MAIN_PND]) begin
        main_low_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt and reset outputs
  // ----------------------------------------------------------------------
  // Interrupt tracks pending flags; reset tracks live filtered levels
  always_ff @(posedge mclk) begin
    if (rst) begin
      supervisor_irq   <= 1'b0;
      supervisor_reset <= 1'b0;
    end else begin
      supervisor_irq <= supervisor_output_enable &&
        (core_overcurrent_pending || core_low_pending || main_low_pending);
      supervisor_reset <= supervisor_output_enable &&
        ((core_supply_reset_enable && core_seen) ||
         (main_supply_reset_enable && main_seen));
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Registered read data; unmapped addresses and reserved bits read zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        LVS_ADDR_CONTROL: sfr_rdata <= supervisor_control;
        LVS_ADDR_FLAGS:   sfr_rdata <= {1'b0, core_overcurrent_pending, core_low_pending,
                                        main_low_pending, main_low_sync_bypass,
                                        overcurrent_filter_bypass,
                                        core_low_filter_bypass, main_low_filter_bypass};
        LVS_ADDR_HIGH:    sfr_rdata <= {1'b0, filter_high_count_value};
        LVS_ADDR_LOW:     sfr_rdata <= {1'b0, filter_low_count_value};
        default:          sfr_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// ### testbench/lvs_supervisor_chk.sv
/* Concurrent checks on the ports of lvs_supervisor.
   Assumes one mclk domain; bound onto every lvs_supervisor instance. */
`timescale 1ns/1ps
module lvs_supervisor_chk
  import lvs_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [1:0] clock_config_five,
  input wire logic       main_low_raw,
  input wire logic       core_low_raw,
  input wire logic       overcurrent_raw,
  input wire logic [1:0] main_supply_threshold_select,
  input wire logic       core_supply_detect_enable,
  input wire logic       main_supply_detect_enable,
  input wire logic       supervisor_irq,
  input wire logic       supervisor_reset
);
  // ----------------------------------------
  // Register mirrors
  // ----------------------------------------
  logic [7:0] ctl_s;  // Control as last written
  logic [3:0] byp_s;  // Bypass bits as last written
  // Control mirror, same edge as the design register
  always_ff @(posedge mclk) begin
    if (rst) ctl_s <= LVS_CTL_RESET;
    else if (sfr_wr && sfr_addr == LVS_ADDR_CONTROL) ctl_s <= {1'b0, sfr_wdata[6:0]};
  end
  // Bypass mirror
  always_ff @(posedge mclk) begin
    if (rst) byp_s <= LVS_BYP_RESET;
    else if (sfr_wr && sfr_addr == LVS_ADDR_FLAGS) byp_s <= sfr_wdata[3:0];
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Held anomalies with every gate open; five cycles cover the copy register
  sequence s_core_held;
    (ctl_s[6:5] == 2'b11 && ctl_s[1] && byp_s[1] && core_low_raw) [*5];
  endsequence
  sequence s_main_held;
    (ctl_s[6] && ctl_s[4] && ctl_s[0] && byp_s[3] && byp_s[0] && main_low_raw) [*5];
  endsequence
  sequence s_oc_held;
    (ctl_s[6] && byp_s[2] && overcurrent_raw) [*5];
  endsequence
  property p_core_rst;
    s_core_held |-> supervisor_reset;
  endproperty
  a_core_rst: assert property (p_core_rst)
    else $error("core low did not reset");
  property p_main_rst;
    s_main_held |-> supervisor_reset;
  endproperty
  a_main_rst: assert property (p_main_rst)
    else $error("main low did not reset");
  property p_oc_irq;
    s_oc_held |-> supervisor_irq;
  endproperty
  a_oc_irq: assert property (p_oc_irq)
    else $error("overcurrent raised no interrupt");
  property p_rst_cause;
    supervisor_reset |-> $past(ctl_s[6]) && ($past(ctl_s[5]) || $past(ctl_s[4]));
  endproperty
  a_rst_cause: assert property (p_rst_cause)
    else $error("reset without its enables");
  property p_irq_oe;
    supervisor_irq |-> $past(ctl_s[6]);
  endproperty
  a_irq_oe: assert property (p_irq_oe)
    else $error("interrupt while output disabled");
  property p_irq_fall;
    $fell(supervisor_irq) |-> $past(rst) || !$past(ctl_s[6])
      || $past(sfr_wr && sfr_addr == LVS_ADDR_FLAGS, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped with no clear");
  property p_thr_copy;
    main_supply_threshold_select == $past(ctl_s[3:2]);
  endproperty
  a_thr_copy: assert property (p_thr_copy)
    else $error("threshold select differs from control");
  property p_det_copy;
    {core_supply_detect_enable, main_supply_detect_enable} == $past(ctl_s[1:0]);
  endproperty
  a_det_copy: assert property (p_det_copy)
    else $error("detect enables differ from control");
  property p_rd_ctl;
    sfr_rd && !sfr_wr && sfr_addr == LVS_ADDR_CONTROL |=> sfr_rdata == $past(ctl_s);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl)
    else $error("control read back wrong");
  property p_rd_unmapped;
    sfr_rd && (sfr_addr < LVS_ADDR_CONTROL || sfr_addr > LVS_ADDR_LOW) |=> sfr_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
endmodule
bind lvs_supervisor lvs_supervisor_chk u_chk (
  .mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .clock_config_five(clock_config_five),
  .main_low_raw(main_low_raw), .core_low_raw(core_low_raw),
  .overcurrent_raw(overcurrent_raw),
  .main_supply_threshold_select(main_supply_threshold_select),
  .core_supply_detect_enable(core_supply_detect_enable),
  .main_supply_detect_enable(main_supply_detect_enable),
  .supervisor_irq(supervisor_irq), .supervisor_reset(supervisor_reset)
);

// ### testbench/lvs_analog_model.sv
/* Behavioural stand-in for the supply detectors.
   Assumes the bench sets supply_fault just after a clock edge. */
`timescale 1ns/1ps
module lvs_analog_model (
  input  wire logic [2:0] supply_fault,               // Main, core, overcurrent
  input  wire logic       core_supply_detect_enable,  // From supervisor
  input  wire logic       main_supply_detect_enable,  // From supervisor
  output logic            main_low_raw,               // Main low flag
  output logic            core_low_raw,               // Core low flag
  output logic            overcurrent_raw             // Overcurrent flag
);
  // A switched-off detector reports nothing
  assign main_low_raw    = supply_fault[0] & main_supply_detect_enable;
  assign core_low_raw    = supply_fault[1] & core_supply_detect_enable;
  // Overcurrent has no enable
  assign overcurrent_raw = supply_fault[2];
endmodule

// ### testbench/lvs_supervisor_tb.sv
/* Self-checking bench: register port, detection paths, deglitch filter.
   Assumes lvs_analog_model stands in for the analog detectors. */
`timescale 1ns/1ps
module lvs_supervisor_tb
  import lvs_pkg::*;
;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [1:0] clock_config_five = 2'h0;
  logic [2:0] supply_fault = 3'h0;
  logic [7:0] sfr_rdata;
  logic [1:0] thr_sel;
  logic       core_de, main_de, main_raw, core_raw, oc_raw, supervisor_irq, supervisor_reset;
  int         err_total = 0;
  int         checked = 0;
  int         m_reg[4] = '{32'h73, 32'h0F, 32'h02, 32'h02};  // Expected register bytes
  logic [7:0] addr_list[$] = '{8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'h00};
  logic [7:0] ctl_list[$] = '{8'h73, 8'h53, 8'h63, 8'h03, 8'h70};
  always #5 mclk = ~mclk;
  lvs_supervisor DUT (
    .mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .clock_config_five(clock_config_five),
    .main_low_raw(main_raw), .core_low_raw(core_raw), .overcurrent_raw(oc_raw),
    .main_supply_threshold_select(thr_sel), .core_supply_detect_enable(core_de),
    .main_supply_detect_enable(main_de), .supervisor_irq(supervisor_irq),
    .supervisor_reset(supervisor_reset));
  lvs_analog_model u_analog (
    .supply_fault(supply_fault), .core_supply_detect_enable(core_de),
    .main_supply_detect_enable(main_de), .main_low_raw(main_raw),
    .core_low_raw(core_raw), .overcurrent_raw(oc_raw));
  // ----------------------------------------
  // Compare and bus tasks
  // ----------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // One-cycle write strobe, then a spare edge so strobes never merge
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    idle(1);
    sfr_wr = 1'b0;
    if (a == LVS_ADDR_FLAGS) m_reg[1] = (m_reg[1] & 32'h70 & ~{24'h0, d}) | {24'h0, d & 8'h0F};
    else if (a >= LVS_ADDR_CONTROL && a <= LVS_ADDR_LOW) m_reg[a - 8'hBA] = {24'h0, d & 8'h7F};
    idle(1);
  endtask
  task automatic read_check(input logic [7:0] a);
    logic [7:0] exp;
    exp = (a >= LVS_ADDR_CONTROL && a <= LVS_ADDR_LOW) ? 8'(m_reg[a - 8'hBA]) : 8'h00;
    sfr_addr = a;
    sfr_rd = 1'b1;
    idle(1);
    sfr_rd = 1'b0;
    chk_byte(sfr_rdata, exp);
    idle(1);
  endtask
  task automatic pins_check();
    chk_byte({4'h0, thr_sel, core_de, main_de}, 8'(m_reg[0] & 15));
  endtask
  // Bypassed detection of one channel, then write-0 and write-1 on its flag
  task automatic fault_case(input logic [7:0] c, input logic [7:0] f, input int ch);
    logic det;
    logic rst_exp;
    sfr_write(LVS_ADDR_CONTROL, c);
    sfr_write(LVS_ADDR_FLAGS, f);
    det = (ch == 2) || c[ch];
    rst_exp = det && c[6] && ((ch == 0 && c[4]) || (ch == 1 && c[5]));
    supply_fault = 3'b001 << ch;
    idle(8);
    chk_bit(supervisor_reset, rst_exp);
    chk_bit(supervisor_irq, det && c[6]);
    supply_fault = 3'b000;
    if (det) m_reg[1] |= 32'h10 << ch;
    idle(8);
    chk_bit(supervisor_reset, 1'b0);
    sfr_write(LVS_ADDR_FLAGS, f & 8'h0F);
    read_check(LVS_ADDR_FLAGS);
    sfr_write(LVS_ADDR_FLAGS, f | (8'h10 << ch));
    read_check(LVS_ADDR_FLAGS);
    chk_bit(supervisor_irq, 1'b0);
  endtask
  task automatic conclude();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [7:0] a;
    int hi, lo, div, n;
    void'($urandom(39));
    idle(4);
    rst = 1'b0;
    foreach (addr_list[k]) read_check(addr_list[k]);
    pins_check();
    $display("reset values done");
    for (int k = 0; k < 12; k++) begin
      a = 8'hBA + 8'($urandom % 5);
      sfr_write(a, 8'($urandom));
      pins_check();
      foreach (addr_list[j]) read_check(addr_list[j]);
    end
    $display("random register access done");
    for (int s = 0; s < 2; s++) begin
      foreach (ctl_list[c]) begin
        for (int ch = 0; ch < 3; ch++) fault_case(ctl_list[c], s ? 8'h07 : 8'h0F, ch);
      end
    end
    $display("bypassed detection done");
    // Filtered core channel at three filter clock rates
    for (int sel = 0; sel < 3; sel++) begin
      hi = 2 + $urandom % 4;
      lo = 2 + $urandom % 4;
      div = 1 << (4 * sel);
      clock_config_five = 2'(sel);
      // Counts first, so a stale filter level settles before filters engage
      sfr_write(LVS_ADDR_HIGH, 8'(hi));
      sfr_write(LVS_ADDR_LOW, 8'(lo));
      sfr_write(LVS_ADDR_CONTROL, 8'h73);
      sfr_write(LVS_ADDR_FLAGS, 8'h08);
      supply_fault = 3'b010;
      idle((hi - 1) * div);
      supply_fault = 3'b000;
      idle(3 * div + 4);
      chk_bit(supervisor_reset, 1'b0);
      read_check(LVS_ADDR_FLAGS);
      supply_fault = 3'b010;
      n = 0;
      while (supervisor_reset !== 1'b1 && n < 2000) begin
        idle(1);
        n++;
      end
      chk_bit(n >= (hi - 1) * div && n <= (hi + 1) * div + 4, 1'b1);
      supply_fault = 3'b000;
      m_reg[1] |= 32'h20;
      idle((lo - 1) * div);
      chk_bit(supervisor_reset, 1'b1);
      idle(2 * div + 4);
      chk_bit(supervisor_reset, 1'b0);
      sfr_write(LVS_ADDR_FLAGS, 8'h28);
      read_check(LVS_ADDR_FLAGS);
    end
    $display("filtered detection done");
    conclude();
  end
  // Whole run is a few thousand cycles; this limit is far beyond it
  initial begin
    #400000;
    err_total++;
    conclude();
  end
endmodule
